// >>> design/frh_device.sv
`timescale 1ns/1ps
// Behaviour
// - Answer select code 50 octal, mask bit 2
// - Interrupt if no request 5 ms after load
// - Device pulse acts as local reset
// - Reset loads both pointers with 4
// - Reset: loop mode, out flag 0, in flag 1
// - Reset reinitialises controller and generators
// - Input read returns word; fourth toggles flag
// - Host reads input only in diag/loop; device does not check mode on input reads
// - Status word: addresses, flags, mode
// - Pointers hold only 4 through 7
// - Input flag 0 host reads, 1 controller
// - Output flag 0 host writes, 1 controller
// - Mode codes 11,10,01,00
// - Loop mode: flag toggles per 4 writes
// - Output write stores word; fourth toggles flag
// - Host writes only when out flag clear; device does not check the flag on output writes
// - New parameters restart generator first in normal/diag mode
// - Control write loads mode field
// - Mainbeam fraction saturates at 256
// - Fixed fraction saturates at 16
// - Rate factor legal 64 to 4095
module frh_device
  import frh_pkg::*;
#(
  parameter int TIMEOUT_CYC = FRH_TIMEOUT_CYC
) (
  input wire logic clk_i,                 // 200 MHz clock
  input wire logic reset_i,               // Sync reset, active high
  frh_if.dev bus,                         // Host I/O bus
  input wire logic ctl_out_take_i,        // Controller takes output block
  input wire logic ctl_gen_req_i,         // Generator requests data
  input wire logic ctl_in_we_i,           // Controller writes input word
  input wire logic [15:0] ctl_in_data_i,  // Input word from controller
  output logic [63:0] ctl_out_block_o,    // Output buffer contents
  output logic [1:0] ctl_mode_o,          // Current interface mode
  output logic ctl_init_o,                // Reinit controller and generators
  output logic gen_restart_o,             // Generator restart pulse
  output logic [8:0] gen_mainbeam_o,      // Saturated mainbeam fraction
  output logic [4:0] gen_fixed_o,         // Saturated fixed fraction
  output logic [11:0] gen_rate_o,         // Rate scaling factor
  output logic gen_rate_bad_o,            // Rate factor out of range
  output logic gen_enable_o               // Generation allowed
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] optr;
    logic [2:0] iptr;
    logic oflag;
    logic iflag;
    frh_mode_e mode;
    logic [3:0][15:0] obuf;
    logic [3:0][15:0] ibuf;
    logic [31:0] tmo;
    logic tmo_run;
    logic irq;
    logic [15:0] rdata;
    logic init;
    logic restart;
    logic [8:0] mb;
    logic [4:0] fix;
    logic [11:0] rate;
    logic rate_bad;
    logic gen_en;
  } frh_dev_s;

  frh_dev_s s_q, s_d;
  logic sel;
  logic loc_rst;
  logic [1:0] oidx, iidx;
  logic [15:0] st_word;

  // Select decode and local reset
  assign sel = (bus.dev_sel == FRH_DEV_CODE);
  assign loc_rst = bus.global_io_reset | (sel & bus.dev_pulse);
  assign oidx = s_q.optr[1:0];
  assign iidx = s_q.iptr[1:0];

  // Status word assembly
  always_comb begin
    st_word = '0;
    st_word[FRH_ST_OADDR_LSB +: 3] = s_q.optr;
    st_word[FRH_ST_IADDR_LSB +: 3] = s_q.iptr;
    st_word[FRH_ST_IS_POS] = s_q.iflag;
    st_word[FRH_ST_OS_POS] = s_q.oflag;
    st_word[FRH_ST_MODE_LSB +: 2] = s_q.mode;
  end

  // Next state
  always_comb begin
    logic [15:0] w;
    logic hit;
    w = '0;
    hit = 1'b0;
    s_d = s_q;
    s_d.init = 1'b0;
    s_d.restart = 1'b0;
    // Host output write into output buffer
    if (sel && bus.output_word_write) begin
      s_d.obuf[oidx] = bus.data_out;
      if (s_q.optr == FRH_PTR_LAST) begin
        s_d.optr = FRH_PTR_FIRST;
        s_d.oflag = ~s_q.oflag;
        s_d.tmo = '0;
        s_d.tmo_run = (s_q.mode != FRH_MODE_LOOP);
        // Parameter block delivered in normal/diag mode: restart generator first
        if (s_q.mode == FRH_MODE_NORMAL || s_q.mode == FRH_MODE_DIAG) begin
          s_d.restart = 1'b1;
        end
      end else begin
        s_d.optr = s_q.optr + 3'h1;
      end
    end
    // Controller takes output block (not in loop mode)
    if (ctl_out_take_i && s_q.oflag && s_q.mode != FRH_MODE_LOOP) begin
      s_d.oflag = 1'b0;
    end
    // Generator request clears the timeout
    if (ctl_gen_req_i) begin
      s_d.tmo_run = 1'b0;
      s_d.tmo = '0;
    end else if (s_q.tmo_run) begin
      if (s_q.tmo == TIMEOUT_CYC - 1) begin
        s_d.irq = 1'b1;
        hit = 1'b1;
        s_d.tmo_run = 1'b0;
      end else begin
        s_d.tmo = s_q.tmo + 32'h1;
      end
    end
    // Controller writes input buffer while it owns it
    if (ctl_in_we_i && s_q.iflag) begin
      s_d.ibuf[iidx] = ctl_in_data_i;
      if (s_q.iptr == FRH_PTR_LAST) begin
        s_d.iptr = FRH_PTR_FIRST;
        s_d.iflag = 1'b0;
      end else begin
        s_d.iptr = s_q.iptr + 3'h1;
      end
    end
    // Host input read
    if (sel && bus.input_word_read) begin
      s_d.rdata = s_q.ibuf[iidx];
      if (s_q.iptr == FRH_PTR_LAST) begin
        s_d.iptr = FRH_PTR_FIRST;
        s_d.iflag = ~s_q.iflag;
      end else begin
        s_d.iptr = s_q.iptr + 3'h1;
      end
    end else if (sel && bus.status_word_read) begin
      s_d.rdata = st_word;
    end
    // Mode control and interrupt acknowledge
    if (sel && bus.mode_control_write) begin
      s_d.mode = frh_mode_e'(bus.data_out[FRH_CTL_MODE_LSB +: 2]);
      s_d.irq = hit;                                                 // Fresh timeout wins
    end
    if (sel && (bus.output_word_write || bus.input_word_read)) begin
      s_d.irq = s_d.irq & ~(ctl_gen_req_i);
    end
    // Decode parameter words from the output block
    w = s_d.obuf[1];
    s_d.mb = (w >= FRH_MB_MAX) ? FRH_MB_MAX[8:0] : w[8:0];
    w = s_d.obuf[2];
    s_d.fix = (w >= FRH_FIX_MAX) ? FRH_FIX_MAX[4:0] : w[4:0];
    w = s_d.obuf[3];
    s_d.rate = w[11:0];
    s_d.rate_bad = (w < FRH_RATE_MIN) || (w > FRH_RATE_MAX);
    s_d.gen_en = (s_d.mode != FRH_MODE_LOOP) && !s_d.rate_bad;
    // Local or global reset
    if (loc_rst) begin
      s_d.optr = FRH_PTR_FIRST;
      s_d.iptr = FRH_PTR_FIRST;
      s_d.mode = FRH_MODE_LOOP;
      s_d.oflag = FRH_OUT_OWNER_RST;
      s_d.iflag = FRH_IN_OWNER_RST;
      s_d.tmo_run = 1'b0;
      s_d.tmo = '0;
      s_d.irq = 1'b0;
      s_d.init = 1'b1;
      s_d.gen_en = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.optr <= FRH_PTR_FIRST;
      s_q.iptr <= FRH_PTR_FIRST;
      s_q.mode <= FRH_MODE_LOOP;
      s_q.oflag <= FRH_OUT_OWNER_RST;
      s_q.iflag <= FRH_IN_OWNER_RST;
      s_q.init <= 1'b1;
      s_q.rate_bad <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign bus.data_in = s_q.rdata;
  assign bus.intr_req = s_q.irq;
  assign ctl_out_block_o = s_q.obuf;
  assign ctl_mode_o = s_q.mode;
  assign ctl_init_o = s_q.init;
  assign gen_restart_o = s_q.restart;
  assign gen_mainbeam_o = s_q.mb;
  assign gen_fixed_o = s_q.fix;
  assign gen_rate_o = s_q.rate;
  assign gen_rate_bad_o = s_q.rate_bad;
  assign gen_enable_o = s_q.gen_en;
endmodule

// >>> design/frh_host.sv
`timescale 1ns/1ps
// Host side: turns user requests into single-cycle bus instructions
module frh_host
  import frh_pkg::*;
(
  input wire logic clk_i,              // 200 MHz clock
  input wire logic reset_i,            // Sync reset, active high
  frh_if.host bus,                     // Host I/O bus
  input wire logic req_i,              // Request strobe
  input wire logic [2:0] op_i,         // 0 rd in,1 wr out,2 status,3 mode,4 pulse,5 reset
  input wire logic [15:0] wdata_i,     // Write data
  output logic busy_o,                 // Request in flight
  output logic done_o,                 // Completion pulse
  output logic [15:0] rdata_o,         // Read data
  output logic irq_o                   // Device interrupt level
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op;
    logic [15:0] wd;
    logic issue;
    logic [5:0] strb;
    logic wait_rd;
    logic busy;
    logic done;
    logic [15:0] rd;
    logic irq;
  } frh_host_s;

  frh_host_s s_q, s_d;

  // Sequencing: cycle 1 issue, cycle 2 capture
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.irq = bus.intr_req;
    s_d.issue = 1'b0;
    s_d.strb = '0;
    if (s_q.wait_rd) begin
      s_d.rd = bus.data_in;
      s_d.wait_rd = 1'b0;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end else if (s_q.issue) begin
      s_d.wait_rd = (s_q.op == 3'h0) || (s_q.op == 3'h2);
      s_d.busy = s_d.wait_rd;
      s_d.done = !s_d.wait_rd;
    end else if (req_i && !s_q.busy) begin
      s_d.op = op_i;
      s_d.wd = wdata_i;
      s_d.issue = 1'b1;
      s_d.strb = 6'(8'h01 << op_i);
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus strobes during the issue cycle, one-hot from flops
  assign bus.dev_sel = FRH_DEV_CODE;
  assign bus.input_word_read = s_q.strb[0];
  assign bus.output_word_write = s_q.strb[1];
  assign bus.status_word_read = s_q.strb[2];
  assign bus.mode_control_write = s_q.strb[3];
  assign bus.dev_pulse = s_q.strb[4];
  assign bus.global_io_reset = s_q.strb[5];
  assign bus.data_out = s_q.wd;
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign rdata_o = s_q.rd;
  assign irq_o = s_q.irq;
endmodule

// >>> design/frh_if.sv
`timescale 1ns/1ps
// Host programmed-I/O bus toward the fruit reply port
interface frh_if;
  logic [5:0] dev_sel;
  logic input_word_read;
  logic output_word_write;
  logic status_word_read;
  logic mode_control_write;
  logic dev_pulse;
  logic global_io_reset;
  logic [15:0] data_out;
  logic [15:0] data_in;
  logic intr_req;
  modport dev (
    input dev_sel, input_word_read, output_word_write, status_word_read,
    input mode_control_write, dev_pulse, global_io_reset, data_out,
    output data_in, intr_req
  );
  modport host (
    output dev_sel, input_word_read, output_word_write, status_word_read,
    output mode_control_write, dev_pulse, global_io_reset, data_out,
    input data_in, intr_req
  );
endinterface

// >>> design/frh_pkg.sv
package frh_pkg;
  // ------------------------------------------------------------
  // Bus identity
  // ------------------------------------------------------------
  localparam logic [5:0] FRH_DEV_CODE = 6'h28;
  localparam int FRH_MASK_BIT = 2;
  // ------------------------------------------------------------
  // Buffer layout
  // ------------------------------------------------------------
  localparam logic [2:0] FRH_PTR_FIRST = 3'h4;
  localparam logic [2:0] FRH_PTR_LAST = 3'h7;
  localparam logic FRH_OUT_OWNER_RST = 1'h0;
  localparam logic FRH_IN_OWNER_RST = 1'h1;
  // ------------------------------------------------------------
  // Status and control word field positions
  // ------------------------------------------------------------
  localparam int FRH_ST_OADDR_LSB = 5;
  localparam int FRH_ST_IADDR_LSB = 9;
  localparam int FRH_ST_IS_POS = 12;
  localparam int FRH_ST_OS_POS = 13;
  localparam int FRH_ST_MODE_LSB = 14;
  localparam int FRH_CTL_MODE_LSB = 14;
  // ------------------------------------------------------------
  // Parameter word limits
  // ------------------------------------------------------------
  localparam logic [15:0] FRH_MB_MAX = 16'h0100;
  localparam logic [15:0] FRH_FIX_MAX = 16'h0010;
  localparam logic [15:0] FRH_RATE_MIN = 16'h0040;
  localparam logic [15:0] FRH_RATE_MAX = 16'h0FFF;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int FRH_CLK_MHZ = 200;
  localparam int FRH_TIMEOUT_US = 5000;
  localparam int FRH_TIMEOUT_CYC = FRH_TIMEOUT_US * FRH_CLK_MHZ;
  // ------------------------------------------------------------
  // Interface modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FRH_MODE_LOOP = 2'b00,
    FRH_MODE_ATB = 2'b01,
    FRH_MODE_DIAG = 2'b10,
    FRH_MODE_NORMAL = 2'b11
  } frh_mode_e;
endpackage

// >>> sim/frh_monitor.sv
`timescale 1ns/1ps
// ----
// Interface checker
// ----
module frh_monitor
  import frh_pkg::*;
#(
  parameter int TIMEOUT_CYC = FRH_TIMEOUT_CYC
) (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Sync reset
  input wire logic [5:0] dev_sel, // Select
  input wire logic input_word_read, // Input read
  input wire logic output_word_write, // Output write
  input wire logic status_word_read, // Status read
  input wire logic mode_control_write, // Mode write
  input wire logic dev_pulse, // Local reset
  input wire logic global_io_reset, // Global reset
  input wire logic [15:0] data_out, // Host data
  input wire logic [15:0] data_in, // Device data
  input wire logic intr_req // Interrupt
);
  logic sel, clr, clr_mw, rd_st, fresh_q, os_q, os_ok_q;
  logic [1:0] mode_q, oc_q, ic_q;
  int since_q;
  assign sel = dev_sel == FRH_DEV_CODE;
  assign clr = reset_i || global_io_reset || (sel && dev_pulse);
  assign rd_st = sel && status_word_read;
  assign clr_mw = clr || (sel && mode_control_write);
  // Shadow of mode, pointers and loop-mode owner flag
  always_ff @(posedge clk_i) begin
    if (clr) begin
      mode_q <= 2'h0; oc_q <= 2'h0; ic_q <= 2'h0; since_q <= 0;
      fresh_q <= 1'b1; os_q <= 1'b0; os_ok_q <= 1'b1;
    end else begin
      since_q <= since_q + 1;
      if (sel && mode_control_write) mode_q <= data_out[15:14];
      if (mode_q != FRH_MODE_LOOP) os_ok_q <= 1'b0;
      if (sel && input_word_read) begin
        ic_q <= ic_q + 2'h1; fresh_q <= 1'b0;
      end
      if (sel && output_word_write) begin
        oc_q <= oc_q + 2'h1; fresh_q <= 1'b0;
        if (oc_q == 2'h3) begin
          os_q <= ~os_q; since_q <= 0;
        end
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_mode_field: assert property (rd_st |=> data_in[15:14] == mode_q)
    else $error("status mode field wrong");
  a_out_addr: assert property (rd_st |=> data_in[7:5] == {1'b1, oc_q})
    else $error("output address wrong");
  a_in_addr: assert property (rd_st |=> data_in[11:9] == {1'b1, ic_q})
    else $error("input address wrong");
  a_reset_flags: assert property (rd_st && fresh_q |=> data_in[13:12] == 2'b01)
    else $error("owner flags after reset wrong");
  a_loop_owner: assert property (rd_st && os_ok_q |=> data_in[13] == os_q)
    else $error("loop mode output flag wrong");
  a_data_hold: assert property (!(sel && (input_word_read || status_word_read)) && !clr
    |=> $stable(data_in)) else $error("read data changed unasked");
  a_intr_early: assert property ($rose(intr_req) |->
    since_q + 2 >= TIMEOUT_CYC && mode_q != FRH_MODE_LOOP) else $error("early interrupt");
  a_intr_clear: assert property ($fell(intr_req) |-> $past(clr_mw))
    else $error("interrupt dropped");
  c_normal: cover property (rd_st && mode_q == FRH_MODE_NORMAL);
  c_intr: cover property ($rose(intr_req));
  c_pulse: cover property (sel && dev_pulse);
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
// ----
// Testbench
// ----
module tb_top
  import frh_pkg::*;
;
  logic clk_i = 0, reset_i = 1, req_i = 0, take_i = 0, greq_i = 0, cwe_i = 0;
  logic [2:0] op_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000, cdata_i = 16'h0000, lf = 16'h0026, rd;
  logic busy_o, done_o, irq_o, init_o, rst_o, bad_o, en_o, os, is;
  logic [63:0] blk_o;
  logic [15:0] rdata_o, words [4];
  logic [8:0] mb_o;
  logic [4:0] fx_o;
  logic [11:0] rate_o;
  logic [1:0] mode_o, oa, ia;
  int num_errors = 0, checked = 0, n_init = 0, n_rst = 0, r0 = 0;
  frh_if bus_if ();
  frh_host frh_host_i (.clk_i, .reset_i, .bus(bus_if.host), .req_i, .op_i, .wdata_i,
    .busy_o, .done_o, .rdata_o, .irq_o);
  frh_device #(.TIMEOUT_CYC(20)) frh_device_i (.clk_i, .reset_i, .bus(bus_if.dev),
    .ctl_out_take_i(take_i), .ctl_gen_req_i(greq_i), .ctl_in_we_i(cwe_i),
    .ctl_in_data_i(cdata_i), .ctl_out_block_o(blk_o), .ctl_mode_o(mode_o), .ctl_init_o(init_o),
    .gen_restart_o(rst_o), .gen_mainbeam_o(mb_o), .gen_fixed_o(fx_o), .gen_rate_o(rate_o),
    .gen_rate_bad_o(bad_o), .gen_enable_o(en_o));
  frh_monitor #(.TIMEOUT_CYC(20)) frh_monitor_i (.clk_i, .reset_i, .dev_sel(bus_if.dev_sel),
    .input_word_read(bus_if.input_word_read), .output_word_write(bus_if.output_word_write),
    .status_word_read(bus_if.status_word_read), .mode_control_write(bus_if.mode_control_write),
    .dev_pulse(bus_if.dev_pulse), .global_io_reset(bus_if.global_io_reset),
    .data_out(bus_if.data_out), .data_in(bus_if.data_in), .intr_req(bus_if.intr_req));
  // Clock and pulse catchers
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (init_o) n_init <= n_init + 1;
    if (rst_o) n_rst <= n_rst + 1;
  end
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] stw(logic [1:0] m);
    return {m, os, is, 1'b1, ia, 1'b0, 1'b1, oa, 5'h00};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic [15:0] w);
    int n;
    @(negedge clk_i);
    req_i = 1; op_i = c; wdata_i = w;
    @(negedge clk_i);
    req_i = 0;
    chk("busy", 16'h1, {15'h0, busy_o});
    for (n = 0; n < 20 && done_o !== 1'b1; n++) @(negedge clk_i);
    chk("done", 16'h0, {15'h0, n == 20});
    rd = rdata_o;
  endtask
  task automatic st_chk(input logic [1:0] m);
    op(3'h2, 16'h0000);
    chk("status", stw(m), rd & 16'hFEE0);
  endtask
  task automatic hw(input logic [15:0] w);
    op(3'h1, w); oa++;
    if (oa == 0) os = ~os;
  endtask
  task automatic cw(input logic [15:0] d);
    @(negedge clk_i); cwe_i = 1; cdata_i = d;
    @(negedge clk_i); cwe_i = 0;
    if (is) begin
      ia++;
      if (ia == 0) is = 0;
    end
  endtask
  task automatic load(input logic [15:0] mb, input logic [15:0] fx, input logic [15:0] rt);
    hw(16'h0000); hw(mb); hw(fx); hw(rt);
  endtask
  task automatic init_model;
    oa = 0; ia = 0; os = 0; is = 1;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    init_model();
    repeat (6) @(negedge clk_i);
    reset_i = 0;
    st_chk(FRH_MODE_LOOP);
    chk("init", 16'h1, {15'h0, n_init != 0});
    $display("test reset ended");
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf); hw(lf); st_chk(FRH_MODE_LOOP);
    end
    chk("restart_loop", 16'h0, 16'(n_rst));
    for (int i = 0; i < 5; i++) begin
      lf = nxt(lf); words[i % 4] = (i < 4) ? lf : words[i % 4]; cw(lf);
    end
    st_chk(FRH_MODE_LOOP);
    for (int i = 0; i < 4; i++) begin
      op(3'h0, 16'h0000); ia++; is = (ia == 0) ? ~is : is;
      chk("in_word", words[i], rd);
      st_chk(FRH_MODE_LOOP);
    end
    $display("test buffers ended");
    for (int m = 0; m < 4; m++) begin
      op(3'h3, {m[1:0], 14'h0000}); st_chk(m[1:0]);
      chk("ctl_mode", {14'h0, m[1:0]}, {14'h0, mode_o});
    end
    r0 = n_rst;
    load(16'h012C, 16'h0014, 16'h0020);
    @(negedge clk_i); greq_i = 1; @(negedge clk_i); greq_i = 0;
    chk("mainbeam", 16'h0100, {7'h0, mb_o});
    chk("fixed", 16'h0010, {11'h0, fx_o});
    chk("rate_bad", 16'h1, {15'h0, bad_o});
    chk("enable_bad", 16'h0, {15'h0, en_o});
    chk("restart", 16'h1, 16'(n_rst - r0));
    repeat (30) @(negedge clk_i);
    chk("irq_held", 16'h0, {15'h0, irq_o});
    st_chk(FRH_MODE_NORMAL);
    take_i = 1; @(negedge clk_i); take_i = 0; os = 0;
    r0 = n_rst;
    load(16'h0080, 16'h0005, 16'h0040);
    chk("mainbeam", 16'h0080, {7'h0, mb_o});
    chk("fixed", 16'h0005, {11'h0, fx_o});
    chk("rate", 16'h0040, {4'h0, rate_o});
    chk("rate_ok", 16'h0, {15'h0, bad_o});
    chk("enable_on", 16'h1, {15'h0, en_o});
    chk("block", 16'h0080, blk_o[31:16]);
    repeat (30) @(negedge clk_i);
    chk("restart2", 16'h1, 16'(n_rst - r0));
    chk("irq", 16'h1, {15'h0, irq_o});
    op(3'h3, 16'h0000);
    @(negedge clk_i);
    chk("irq_clr", 16'h0, {15'h0, irq_o});
    chk("enable", 16'h0, {15'h0, en_o});
    $display("test generator ended");
    hw(16'h1234); op(3'h3, 16'hC000); r0 = n_init; op(3'h4, 16'h0000); init_model();
    st_chk(FRH_MODE_LOOP);
    chk("init_pulse", 16'h1, 16'(n_init - r0));
    hw(16'h4321); r0 = n_init; op(3'h5, 16'h0000); init_model();
    st_chk(FRH_MODE_LOOP);
    chk("init_global", 16'h1, 16'(n_init - r0));
    $display("test resets ended");
    end_sim();
  end
endmodule
